// >>> inc/t1_alarm_pkg.sv
// Purpose: Shared constants for the T1 alarm and overflow interrupt status block.
// Assumes: One 40 MHz clock; register port page and address as seen by the block.
// Notes: Every offset, bit position, reset value and timing count lives here.

package t1_alarm_pkg;

  // ***********************************************************************
  // Register map
  // ***********************************************************************
  localparam logic [3:0] REG_PAGE = 4'h4;
  localparam logic [4:0] ADDR_COUNTER_OVF = 5'h1D;
  localparam logic [4:0] ADDR_LINK_EVENT = 5'h1E;
  localparam logic [4:0] ADDR_OVF_LATCH = 5'h1F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ***********************************************************************
  // Bit positions
  // ***********************************************************************
  localparam int unsigned BIT_FRAMING = 7;
  localparam int unsigned BIT_CRC6 = 6;
  localparam int unsigned BIT_FRAME_LOSS = 5;
  localparam int unsigned BIT_REALIGN = 4;
  localparam int unsigned BIT_LINE_VIOL = 3;
  localparam int unsigned BIT_PATTERN_ERR = 2;
  localparam int unsigned BIT_PATTERN_MF = 1;
  localparam int unsigned BIT_MF_LOSS = 0;
  localparam int unsigned BIT_LINK_A = 7;
  localparam int unsigned BIT_LINK_B = 6;
  localparam int unsigned BIT_LINK_C = 5;
  localparam int unsigned BIT_LOOP_CODE = 4;
  localparam int unsigned BIT_ONE_SEC = 3;
  localparam int unsigned BIT_FIVE_SEC = 2;
  localparam int unsigned BIT_MESSAGE = 1;
  localparam int unsigned BIT_SIGNALLING = 0;
  localparam int unsigned NUM_COUNTERS = 8;

  // ***********************************************************************
  // Counter wrap and pattern constants
  // ***********************************************************************
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam int unsigned LOOP_UP_PERIOD = 5;
  localparam int unsigned LOOP_DOWN_PERIOD = 3;
  localparam logic [7:0] MSG_HEADER = 8'hFE;
  localparam int unsigned MSG_LEN = 15;
  localparam int unsigned MSG_CODE_W = 6;
  localparam int unsigned MSG_WINDOW = 10;
  localparam logic [3:0] MSG_ACCEPT = 4'h8;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int unsigned CLOCK_KHZ = 40000;
  localparam int unsigned LOOP_HOLD_MS = 48;
  localparam int unsigned LOOP_HOLD_CYCLES = LOOP_HOLD_MS * CLOCK_KHZ;
  localparam int unsigned SIG_DEBOUNCE_CYCLES = 16;

  // True when an 8-bit counter has just rolled over from all ones to zero.
  function automatic logic counter_wrapped(input logic [7:0] prev, input logic [7:0] cur);
    return (prev == CNT_MAX) && (cur == CNT_ZERO);
  endfunction

endpackage

// >>> design/loop_code_detector.sv
// Purpose: Detects a repeating loop-up or loop-down code held on the line for the hold time.
// Assumes: line_bit_en pulses once per received line bit.
// Notes: The pulse fires once per unbroken stretch of one code.

module loop_code_detector #(
  parameter int unsigned HOLD_CYCLES = t1_alarm_pkg::LOOP_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic line_bit,
  input wire logic line_bit_en,
  output logic detect_pulse
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

  logic [4:0] hist_ff;
  logic up_ok;
  logic down_ok;
  logic [1:0] code_now;
  logic [1:0] code_ff;
  logic [CW-1:0] hold_cnt_ff;

  // Counts ones in a five-bit window.
  function automatic logic [2:0] ones(input logic [4:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
  endfunction

  // A code is present when the bit repeats its period and the period holds a single one.
  assign up_ok = (line_bit == hist_ff[t1_alarm_pkg::LOOP_UP_PERIOD-1])
    && (ones({hist_ff[3:0], line_bit}) == 3'h1);
  assign down_ok = (line_bit == hist_ff[t1_alarm_pkg::LOOP_DOWN_PERIOD-1])
    && (ones({2'h0, hist_ff[1:0], line_bit}) == 3'h1);

  // Loop-up wins, since its bits also pass the shorter test at some positions.
  assign code_now = up_ok ? 2'h2 : {1'b0, down_ok};

  // Bit history and the code seen at the last bit.
  always_ff @(posedge clock) begin
    if (rst) begin
      hist_ff <= 5'h00;
      code_ff <= 2'h0;
    end else if (line_bit_en) begin
      hist_ff <= {hist_ff[3:0], line_bit};
      code_ff <= code_now;
    end
  end

  // Hold timer restarts whenever the code breaks or switches.
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_cnt_ff <= '0;
    end else if (code_ff == 2'h0 || (line_bit_en && code_ff != code_now)) begin
      hold_cnt_ff <= '0;
    end else if (hold_cnt_ff != CW'(HOLD_CYCLES)) begin
      hold_cnt_ff <= hold_cnt_ff + CW'(1); // [RULE_12]
    end
  end

  // Pulse on the step from the last count to full, so a steady bit stream still fires once.
  assign detect_pulse = (hold_cnt_ff == HOLD_LAST) && (code_ff != 2'h0)
    && !(line_bit_en && code_ff != code_now); // [RULE_12]

endmodule // loop_code_detector

// >>> design/message_validator.sv
// Purpose: Finds data-link messages and accepts a new one after it persists.
// Assumes: fdl_bit_en pulses once per data-link bit.
// Notes: Keeps the codes of the last ten message positions.

module message_validator (
  input wire logic clock,
  input wire logic rst,
  input wire logic facility_data_link,
  input wire logic fdl_bit_en,
  output logic new_message_pulse
);

  localparam int unsigned W = t1_alarm_pkg::MSG_CODE_W;
  localparam int unsigned N = t1_alarm_pkg::MSG_WINDOW;

  logic [t1_alarm_pkg::MSG_LEN-1:0] shift_ff;
  logic [t1_alarm_pkg::MSG_LEN-1:0] nxt_shift;
  logic [W-1:0] hist_ff [N];
  logic [N-1:0] hist_valid_ff;
  logic [W-1:0] accepted_ff;
  logic accepted_valid_ff;
  logic match;
  logic [W-1:0] code;
  logic [3:0] same;

  assign nxt_shift = {shift_ff[t1_alarm_pkg::MSG_LEN-2:0], facility_data_link};
  assign match = fdl_bit_en && (nxt_shift[14:7] == t1_alarm_pkg::MSG_HEADER) && !nxt_shift[0];
  assign code = nxt_shift[W:1];

  // Counts positions among the newest nine that agree with the new code, plus itself.
  always_comb begin
    same = 4'h1;
    for (int i = 0; i < N - 1; i++) begin
      if (hist_valid_ff[i] && hist_ff[i] == code) same = same + 4'h1;
    end
  end

  // Acceptance needs persistence and a change from the message last accepted.
  assign new_message_pulse = match && (same >= t1_alarm_pkg::MSG_ACCEPT)
    && (!accepted_valid_ff || code != accepted_ff); // [RULE_15] [RULE_16]

  // Shift register and message history.
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff <= '0;
      hist_valid_ff <= '0;
      for (int i = 0; i < N; i++) hist_ff[i] <= '0;
    end else if (fdl_bit_en) begin
      shift_ff <= nxt_shift;
      if (match) begin
        hist_ff[0] <= code;
        for (int i = 1; i < N; i++) hist_ff[i] <= hist_ff[i-1];
        hist_valid_ff <= {hist_valid_ff[N-2:0], 1'b1};
      end
    end
  end

  // Last accepted message.
  always_ff @(posedge clock) begin
    if (rst) begin
      accepted_ff <= '0;
      accepted_valid_ff <= 1'b0;
    end else if (new_message_pulse) begin
      accepted_ff <= code;
      accepted_valid_ff <= 1'b1;
    end
  end

endmodule // message_validator

// >>> design/t1_alarm_interrupt_status.sv
// Purpose: Counter overflow, link event and overflow latch status registers for T1 mode.
// Assumes: Inputs synchronous to the 40 MHz clock; one-cycle read strobe from the port.
// Notes: All three registers clear on read; an event in the read cycle survives.
// Behaviour
// RULE_01: Unmasked framing error counter wrap FF to 00 sets its overflow flag.
// RULE_02: Unmasked CRC-6 error counter wrap sets its overflow flag.
// RULE_03: Unmasked out-of-frame counter wrap sets its overflow flag.
// RULE_04: Unmasked frame realignment counter wrap sets its overflow flag.
// RULE_05: Unmasked line code violation counter wrap sets its overflow flag.
// RULE_06: Unmasked test pattern error counter wrap sets its overflow flag.
// RULE_07: Unmasked test pattern multiframe counter wrap sets its overflow flag.
// RULE_08: Unmasked multiframe out-of-sync counter wrap sets its overflow flag.
// RULE_09: A mask bit of one unmasks, zero masks.
// RULE_10: Reading an interrupt register clears its flags.
// RULE_11: Link controller A, B, C interrupts set event bits 7, 6, 5.
// RULE_12: Loop-up or loop-down code held 48 ms sets the loop code flag.
// RULE_13: Rising edge of one-second status sets its flag when unmasked.
// RULE_14: Rising edge of five-second status sets its flag when unmasked.
// RULE_15: A matching data-link message differing from the last sets its flag.
// RULE_16: A new message must appear in 8 of the last 10 positions.
// RULE_17: Signalling pattern change, optionally debounced, sets its flag when unmasked.
// RULE_18: Any counter wrap sets its overflow latch bit, framing at 7.
// RULE_19: Reading the overflow latch clears it.
// RULE_20: A set arriving in the read cycle wins over the clear.

module t1_alarm_interrupt_status #(
  parameter int unsigned LOOP_HOLD_CYCLES = t1_alarm_pkg::LOOP_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] page_sel,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] ovf_int_unmask,
  input wire logic [7:0] event_int_unmask,
  input wire logic [7:0] framing_err_count,
  input wire logic [7:0] crc6_err_count,
  input wire logic [7:0] frame_loss_count,
  input wire logic [7:0] realign_count,
  input wire logic [7:0] line_violation_count,
  input wire logic [7:0] test_pattern_err_count,
  input wire logic [7:0] test_pattern_mf_count,
  input wire logic [7:0] multiframe_loss_count,
  input wire logic link_ctrl_a_irq,
  input wire logic link_ctrl_b_irq,
  input wire logic link_ctrl_c_irq,
  input wire logic line_bit,
  input wire logic line_bit_en,
  input wire logic one_second_status,
  input wire logic five_second_status,
  input wire logic facility_data_link,
  input wire logic fdl_bit_en,
  input wire logic [3:0] signalling_pattern,
  input wire logic signalling_debounce_enable
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  localparam int unsigned NC = t1_alarm_pkg::NUM_COUNTERS;
  localparam logic [4:0] DEB_DONE = 5'(t1_alarm_pkg::SIG_DEBOUNCE_CYCLES);

  logic [7:0] count_now [NC];
  logic [7:0] count_prev_ff [NC];
  logic [NC-1:0] wrap;
  logic [7:0] ovf_set;
  logic [7:0] event_src;
  logic [7:0] event_set;
  logic [7:0] counter_ovf_ff;
  logic [7:0] link_event_ff;
  logic [7:0] ovf_latch_ff;
  logic [7:0] nxt_counter_ovf;
  logic [7:0] nxt_link_event;
  logic [7:0] nxt_ovf_latch;
  logic [7:0] reg_rdata_ff;
  logic page_hit;
  logic rd_ovf;
  logic rd_event;
  logic rd_latch;
  logic one_sec_prev_ff;
  logic five_sec_prev_ff;
  logic loop_detect;
  logic message_new;
  logic [3:0] sig_ref_ff;
  logic [3:0] sig_cand_ff;
  logic [4:0] sig_stable_ff;
  logic sig_change;

  // ***********************************************************************
  // Counter wrap detection
  // ***********************************************************************

  // Counter values ordered by their bit position in the overflow registers.
  assign count_now[t1_alarm_pkg::BIT_FRAMING] = framing_err_count;
  assign count_now[t1_alarm_pkg::BIT_CRC6] = crc6_err_count;
  assign count_now[t1_alarm_pkg::BIT_FRAME_LOSS] = frame_loss_count;
  assign count_now[t1_alarm_pkg::BIT_REALIGN] = realign_count;
  assign count_now[t1_alarm_pkg::BIT_LINE_VIOL] = line_violation_count;
  assign count_now[t1_alarm_pkg::BIT_PATTERN_ERR] = test_pattern_err_count;
  assign count_now[t1_alarm_pkg::BIT_PATTERN_MF] = test_pattern_mf_count;
  assign count_now[t1_alarm_pkg::BIT_MF_LOSS] = multiframe_loss_count;

  // Previous counter values, held to see the roll from all ones to zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NC; i++) count_prev_ff[i] <= t1_alarm_pkg::CNT_ZERO;
    end else begin
      for (int i = 0; i < NC; i++) count_prev_ff[i] <= count_now[i];
    end
  end

  // One wrap pulse per counter; each pulse is one cycle wide.
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      wrap[i] = t1_alarm_pkg::counter_wrapped(count_prev_ff[i], count_now[i]); // [RULE_01]
    end
  end

  // Overflow interrupts pass only where the unmask bit is one.
  assign ovf_set = wrap & ovf_int_unmask; // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_09]

  // ***********************************************************************
  // Event sources
  // ***********************************************************************

  // Edge detectors for the one- and five-second status bits.
  always_ff @(posedge clock) begin
    if (rst) begin
      one_sec_prev_ff <= 1'b0;
      five_sec_prev_ff <= 1'b0;
    end else begin
      one_sec_prev_ff <= one_second_status;
      five_sec_prev_ff <= five_second_status;
    end
  end

  // Loop code timer on the received line bits.
  loop_code_detector #(
    .HOLD_CYCLES(LOOP_HOLD_CYCLES)
  ) u_loop (
    .clock(clock),
    .rst(rst),
    .line_bit(line_bit),
    .line_bit_en(line_bit_en),
    .detect_pulse(loop_detect)
  );

  // Data-link message persistence and change check.
  message_validator u_message (
    .clock(clock),
    .rst(rst),
    .facility_data_link(facility_data_link),
    .fdl_bit_en(fdl_bit_en),
    .new_message_pulse(message_new)
  );

  // Signalling debounce: the new pattern must stand still before it counts.
  always_ff @(posedge clock) begin
    if (rst) begin
      sig_cand_ff <= 4'h0;
      sig_stable_ff <= 5'h00;
    end else if (signalling_pattern != sig_cand_ff) begin
      sig_cand_ff <= signalling_pattern;
      sig_stable_ff <= 5'h00;
    end else if (sig_stable_ff != DEB_DONE) begin
      sig_stable_ff <= sig_stable_ff + 5'h01;
    end
  end

  // Reference pattern follows each reported change.
  always_ff @(posedge clock) begin
    if (rst) begin
      sig_ref_ff <= 4'h0;
    end else if (sig_change) begin
      sig_ref_ff <= signalling_pattern;
    end
  end

  // Change seen directly, or only after the debounce time when that is on.
  assign sig_change = signalling_debounce_enable
    ? (sig_stable_ff == DEB_DONE && sig_cand_ff != sig_ref_ff)
    : (signalling_pattern != sig_ref_ff); // [RULE_17]

  // Event vector in register bit order.
  always_comb begin
    event_src = 8'h00;
    event_src[t1_alarm_pkg::BIT_LINK_A] = link_ctrl_a_irq; // [RULE_11]
    event_src[t1_alarm_pkg::BIT_LINK_B] = link_ctrl_b_irq;
    event_src[t1_alarm_pkg::BIT_LINK_C] = link_ctrl_c_irq;
    event_src[t1_alarm_pkg::BIT_LOOP_CODE] = loop_detect; // [RULE_12]
    event_src[t1_alarm_pkg::BIT_ONE_SEC] = one_second_status && !one_sec_prev_ff; // [RULE_13]
    event_src[t1_alarm_pkg::BIT_FIVE_SEC] = five_second_status && !five_sec_prev_ff; // [RULE_14]
    event_src[t1_alarm_pkg::BIT_MESSAGE] = message_new; // [RULE_15]
    event_src[t1_alarm_pkg::BIT_SIGNALLING] = sig_change;
  end

  assign event_set = event_src & event_int_unmask;

  // ***********************************************************************
  // Register port
  // ***********************************************************************

  // Read strobes for the three status registers.
  assign page_hit = reg_rd && (page_sel == t1_alarm_pkg::REG_PAGE);
  assign rd_ovf = page_hit && (reg_addr == t1_alarm_pkg::ADDR_COUNTER_OVF);
  assign rd_event = page_hit && (reg_addr == t1_alarm_pkg::ADDR_LINK_EVENT);
  assign rd_latch = page_hit && (reg_addr == t1_alarm_pkg::ADDR_OVF_LATCH);

  // Clear on read, then OR in the same cycle's events so none is lost.
  assign nxt_counter_ovf = (rd_ovf ? t1_alarm_pkg::FLAGS_RESET : counter_ovf_ff)
    | ovf_set; // [RULE_10] [RULE_20] [RULE_06] [RULE_07] [RULE_08]
  assign nxt_link_event = (rd_event ? t1_alarm_pkg::FLAGS_RESET : link_event_ff) | event_set;
  assign nxt_ovf_latch = (rd_latch ? t1_alarm_pkg::FLAGS_RESET : ovf_latch_ff)
    | wrap; // [RULE_18] [RULE_19]

  // Status flag registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      counter_ovf_ff <= t1_alarm_pkg::FLAGS_RESET;
      link_event_ff <= t1_alarm_pkg::FLAGS_RESET;
      ovf_latch_ff <= t1_alarm_pkg::FLAGS_RESET;
    end else begin
      counter_ovf_ff <= nxt_counter_ovf;
      link_event_ff <= nxt_link_event;
      ovf_latch_ff <= nxt_ovf_latch;
    end
  end

  // Read data captures the value before its clear; other addresses read zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_ff <= t1_alarm_pkg::UNMAPPED_READ;
    end else if (reg_rd) begin
      if (rd_ovf) begin
        reg_rdata_ff <= counter_ovf_ff; // [RULE_10]
      end else if (rd_event) begin
        reg_rdata_ff <= link_event_ff;
      end else if (rd_latch) begin
        reg_rdata_ff <= ovf_latch_ff;
      end else begin
        reg_rdata_ff <= t1_alarm_pkg::UNMAPPED_READ;
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************

  // Framing counter roll with unmask set raises its flag next cycle.
  property p_framing_wrap;
    @(posedge clock) disable iff (rst)
    ($past(framing_err_count) == 8'hFF && framing_err_count == 8'h00
      && ovf_int_unmask[7]) |=> counter_ovf_ff[7];
  endproperty
  a_framing_wrap: assert property (p_framing_wrap) else $error("framing wrap not flagged"); // [RULE_01]

  // A masked multiframe bit never rises by itself.
  property p_mf_masked;
    @(posedge clock) disable iff (rst)
    (!ovf_int_unmask[1] && !counter_ovf_ff[1]) |=> !counter_ovf_ff[1];
  endproperty
  a_mf_masked: assert property (p_mf_masked) else $error("masked flag rose"); // [RULE_09]

  // A read with no new event leaves the register empty.
  property p_read_clears;
    @(posedge clock) disable iff (rst)
    (rd_ovf && ovf_set == 8'h00) |=> (counter_ovf_ff == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // [RULE_10]

  // Read data returns the register as it stood before the clear.
  property p_read_data;
    @(posedge clock) disable iff (rst)
    rd_ovf |=> (reg_rdata == $past(counter_ovf_ff));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data mismatch"); // [RULE_10]

  // An event in the read cycle is kept for the next read.
  property p_set_wins;
    @(posedge clock) disable iff (rst)
    (rd_event && event_set[6]) |=> link_event_ff[6];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read"); // [RULE_20]

  // Link controller A interrupt lands in bit 7.
  property p_link_a;
    @(posedge clock) disable iff (rst)
    (link_ctrl_a_irq && event_int_unmask[7]) |=> link_event_ff[7];
  endproperty
  a_link_a: assert property (p_link_a) else $error("link A not flagged"); // [RULE_11]

  // One-second rising edge sets its flag when unmasked.
  property p_one_second;
    @(posedge clock) disable iff (rst)
    ($rose(one_second_status) && event_int_unmask[3]) |=> link_event_ff[3];
  endproperty
  a_one_second: assert property (p_one_second) else $error("one second edge missed"); // [RULE_13]

  // A multiframe out-of-sync wrap sets latch bit 0, mask or no mask.
  property p_latch_set;
    @(posedge clock) disable iff (rst)
    wrap[0] |=> ovf_latch_ff[0];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set"); // [RULE_18]

  // Reading the latch with no wrap empties it.
  property p_latch_clear;
    @(posedge clock) disable iff (rst)
    (rd_latch && wrap == 8'h00) |=> (ovf_latch_ff == 8'h00);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // [RULE_19]

endmodule // t1_alarm_interrupt_status

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the T1 alarm and overflow interrupt status block.
// Assumes: One-cycle read strobe; loop code hold shortened to 40 clock cycles.
// Notes: Stimulus always changes 1 ns after the rising clock edge.

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************************
  // Signals and design instance
  // ***********************************************************************
  logic clock, rst, reg_rd, line_bit, line_bit_en, one_second_status, five_second_status;
  logic facility_data_link, fdl_bit_en, signalling_debounce_enable;
  logic link_ctrl_a_irq, link_ctrl_b_irq, link_ctrl_c_irq;
  logic [3:0] page_sel, signalling_pattern;
  logic [4:0] reg_addr;
  logic [7:0] reg_rdata, ovf_int_unmask, event_int_unmask;
  logic [7:0] cnt [8];
  int n_fail, n_checks;
  localparam logic [4:0] A_OVF = t1_alarm_pkg::ADDR_COUNTER_OVF;
  localparam logic [4:0] A_EVT = t1_alarm_pkg::ADDR_LINK_EVENT;
  localparam logic [4:0] A_LAT = t1_alarm_pkg::ADDR_OVF_LATCH;

  t1_alarm_interrupt_status #(.LOOP_HOLD_CYCLES(40)) dut (
    .clock(clock), .rst(rst), .page_sel(page_sel), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ovf_int_unmask(ovf_int_unmask),
    .event_int_unmask(event_int_unmask), .framing_err_count(cnt[7]),
    .crc6_err_count(cnt[6]), .frame_loss_count(cnt[5]), .realign_count(cnt[4]),
    .line_violation_count(cnt[3]), .test_pattern_err_count(cnt[2]),
    .test_pattern_mf_count(cnt[1]), .multiframe_loss_count(cnt[0]),
    .link_ctrl_a_irq(link_ctrl_a_irq), .link_ctrl_b_irq(link_ctrl_b_irq),
    .link_ctrl_c_irq(link_ctrl_c_irq), .line_bit(line_bit), .line_bit_en(line_bit_en),
    .one_second_status(one_second_status), .five_second_status(five_second_status),
    .facility_data_link(facility_data_link), .fdl_bit_en(fdl_bit_en),
    .signalling_pattern(signalling_pattern),
    .signalling_debounce_enable(signalling_debounce_enable));

  // The clock runs at 40 MHz.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ***********************************************************************
  // Tasks
  // ***********************************************************************
  // Waits for n rising edges and steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Compares one value and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // Issues one read strobe, checks the answer, then idles one edge.
  task automatic rd_chk(input logic [3:0] pg, input logic [4:0] a, input logic [7:0] exp);
    page_sel = pg;
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
    tick(1);
  endtask

  // Wraps counter i from all ones to zero, then checks flag, latch and clears.
  task automatic ovf_case(input int i);
    cnt[i] = 8'hFF;
    tick(1);
    cnt[i] = 8'h00;
    tick(1);
    rd_chk(4'h4, A_OVF, 8'(8'h01 << i));
    rd_chk(4'h4, A_LAT, 8'(8'h01 << i));
    rd_chk(4'h4, A_OVF, 8'h00);
    rd_chk(4'h4, A_LAT, 8'h00);
  endtask

  // Sends one data-link message the given number of times, first bit first, then drops the qualifier.
  task automatic send_msg(input logic [5:0] code, input int times);
    logic [14:0] m;
    m = {8'hFE, code, 1'b0};
    repeat (times) begin
      for (int b = 14; b >= 0; b--) begin
        facility_data_link = m[b];
        fdl_bit_en = 1'b1;
        tick(1);
      end
    end
    fdl_bit_en = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ***********************************************************************
  // Test sequence
  // ***********************************************************************
  // Resets the block, then walks through every status source.
  initial begin
    {rst, reg_rd, line_bit, line_bit_en, one_second_status, five_second_status} = 6'h20;
    {facility_data_link, fdl_bit_en, signalling_debounce_enable} = 3'h0;
    {link_ctrl_a_irq, link_ctrl_b_irq, link_ctrl_c_irq} = 3'h0;
    page_sel = 4'h4;
    reg_addr = 5'h00;
    signalling_pattern = 4'h0;
    ovf_int_unmask = 8'hFF;
    event_int_unmask = 8'hFF;
    n_fail = 0;
    n_checks = 0;
    for (int i = 0; i < 8; i++) cnt[i] = 8'h00;
    tick(8);
    rst = 1'b0;
    rd_chk(4'h4, A_OVF, 8'h00);
    rd_chk(4'h4, A_EVT, 8'h00);
    rd_chk(4'h4, A_LAT, 8'h00);
    for (int i = 7; i >= 4; i--) ovf_case(i);
    for (int i = 3; i >= 0; i--) ovf_case(i);
    // A masked wrap still sets its latch bit.
    ovf_int_unmask = 8'hFD;
    ovf_case_masked: begin
      cnt[1] = 8'hFF;
      tick(1);
      cnt[1] = 8'h00;
      tick(1);
    end
    rd_chk(4'h4, A_OVF, 8'h00);
    rd_chk(4'h4, A_LAT, 8'h02);
    ovf_int_unmask = 8'hFF;
    // Link controller pulses; wrong page and unmapped reads must clear nothing.
    {link_ctrl_a_irq, link_ctrl_b_irq, link_ctrl_c_irq} = 3'h7;
    tick(1);
    {link_ctrl_a_irq, link_ctrl_b_irq, link_ctrl_c_irq} = 3'h0;
    tick(1);
    rd_chk(4'h3, A_EVT, 8'h00);
    rd_chk(4'h4, 5'h1C, 8'h00);
    rd_chk(4'h4, A_EVT, 8'hE0);
    // An event in the read cycle survives the clear.
    reg_addr = A_EVT;
    reg_rd = 1'b1;
    link_ctrl_b_irq = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    link_ctrl_b_irq = 1'b0;
    check(reg_rdata, 8'h00);
    tick(1);
    rd_chk(4'h4, A_EVT, 8'h40);
    // Timer rising edges, then again with the one-second source masked.
    {one_second_status, five_second_status} = 2'h3;
    tick(2);
    rd_chk(4'h4, A_EVT, 8'h0C);
    event_int_unmask = 8'hF7;
    {one_second_status, five_second_status} = 2'h0;
    tick(2);
    {one_second_status, five_second_status} = 2'h3;
    tick(2);
    rd_chk(4'h4, A_EVT, 8'h04);
    event_int_unmask = 8'hFF;
    // Signalling change, first plain, then debounced.
    signalling_pattern = 4'h3;
    tick(2);
    rd_chk(4'h4, A_EVT, 8'h01);
    signalling_debounce_enable = 1'b1;
    signalling_pattern = 4'h5;
    tick(4);
    rd_chk(4'h4, A_EVT, 8'h00);
    tick(20);
    rd_chk(4'h4, A_EVT, 8'h01);
    // Loop-up code 00001 held well past the shortened hold time.
    for (int k = 0; k < 300; k++) begin
      line_bit = (k % 5 == 4);
      line_bit_en = 1'b1;
      tick(1);
    end
    line_bit_en = 1'b0;
    rd_chk(4'h4, A_EVT, 8'h10);
    // Data-link messages: seven copies are too few, ten accept, a repeat is quiet.
    send_msg(6'h15, 7);
    rd_chk(4'h4, A_EVT, 8'h00);
    send_msg(6'h15, 3);
    rd_chk(4'h4, A_EVT, 8'h02);
    send_msg(6'h15, 10);
    rd_chk(4'h4, A_EVT, 8'h00);
    send_msg(6'h2A, 10);
    rd_chk(4'h4, A_EVT, 8'h02);
    finish_test();
  end

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

endmodule // tb_top
